// ==== hdtx_pkg.sv ====
// Constants shared by the HD serial transmit coding path
package hdtx_pkg;

  // ********************************************************
  // Word geometry
  // ********************************************************
  localparam int WORD_W = 20;                 // Parallel luma plus chroma word
  localparam int HALF_W = 10;                 // One interleaved component word
  localparam int LUMA_MSB = 19;               // Luma occupies the upper half
  localparam int LUMA_LSB = 10;
  localparam int CHROMA_MSB = 9;              // Chroma occupies the lower half
  localparam int CHROMA_LSB = 0;
  localparam int SYNC_HI_MSB = 9;             // Upper eight bits tested for sync
  localparam int SYNC_HI_LSB = 2;
  localparam int SYNC_LO_W = 2;               // Low bits forced by sync mapping

  // ********************************************************
  // Sync mapping codes
  // ********************************************************
  localparam logic [7:0] SYNC_HI_ZERO = 8'h00;
  localparam logic [7:0] SYNC_HI_ONE = 8'hff;
  localparam logic [1:0] SYNC_LO_ZERO = 2'h0;
  localparam logic [1:0] SYNC_LO_ONE = 2'h3;

  // ********************************************************
  // Scrambler and NRZI
  // ********************************************************
  localparam int LFSR_W = 9;                  // Degree of the scrambler polynomial
  localparam int LFSR_TAP_X4 = 3;             // Stage holding the x^4 term
  localparam int LFSR_TAP_X9 = 8;             // Stage holding the x^9 term
  localparam logic [8:0] LFSR_RST = 9'h000;
  localparam logic NRZI_RST = 1'b0;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CORE_CLK_MHZ = 100;          // Bit clock of this model
  localparam int SER_RATIO = 20;              // Serial bits per parallel clock period
  localparam logic [19:0] WORD_RST = 20'h00000;

endpackage

// ==== hdtx_coder.sv ====
// Bit-serial scrambler and NRZ to NRZI encoder with bypass
`timescale 1ns/1ps
module hdtx_coder (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic bit_i,
  input wire logic bypass_i,
  output logic bit_o
);

  logic [hdtx_pkg::LFSR_W-1:0] scr_q;
  logic [hdtx_pkg::LFSR_W-1:0] scr_d;
  logic nrzi_q;
  logic nrzi_d;
  logic out_q;
  logic out_d;
  logic scr_bit;

  // ********************************************************
  // Scrambler, NRZI and output select
  // ********************************************************
  // Self-synchronising scrambler: feedback from x^4 and x^9 stages
  always_comb begin
    scr_bit = bit_i ^ scr_q[hdtx_pkg::LFSR_TAP_X4] ^ scr_q[hdtx_pkg::LFSR_TAP_X9];
    scr_d = scr_q;
    nrzi_d = nrzi_q;
    out_d = bit_i;
    if (!bypass_i) begin
      scr_d = {scr_q[hdtx_pkg::LFSR_W-2:0], scr_bit};
      nrzi_d = scr_bit ^ nrzi_q;
      out_d = nrzi_d;
    end
  end

  // State runs on across words; only the reset clears it
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      scr_q <= hdtx_pkg::LFSR_RST;
      nrzi_q <= hdtx_pkg::NRZI_RST;
      out_q <= 1'b0;
    end else begin
      scr_q <= scr_d;
      nrzi_q <= nrzi_d;
      out_q <= out_d;
    end
  end

  assign bit_o = out_q;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  a_scr_poly: assert property (!bypass_i |=> scr_q[0] == ($past(bit_i) ^ $past(scr_q[3]) ^ $past(scr_q[8])))
    else $error("Scrambler feedback wrong");
  a_nrzi_enc: assert property (!bypass_i |=> bit_o == (scr_q[0] ^ $past(nrzi_q)))
    else $error("NRZI output wrong");
  a_scr_run: assert property (!bypass_i |=> scr_q[8:1] == $past(scr_q[7:0]))
    else $error("Scrambler did not shift");

endmodule

// ==== hdtx_serializer.sv ====
// Transmit coding path: capture, interleave, sync map, serialise, scramble, NRZI
//
// How it works
// - One 20-bit word accepted per parallel period
// - Bit 19 is MSB, bit 0 LSB
// - All 20 bits captured on parallel clock rise
// - Chroma and luma alternate as 10-bit words
// - Upper eight equal forces low two bits
// - Inhibit high passes words unmodified
// - Scrambler uses polynomial x^9 + x^4 + 1
// - NRZI output is input xor previous output
// - Bypass skips scrambler and NRZI encoder
// - Accepts 8-bit or 10-bit sourced data
// - Serial clock is twenty times parallel clock
`timescale 1ns/1ps
module hdtx_serializer (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic pclk_i,
  input wire logic [19:0] data_i,
  input wire logic sync_map_inhibit_i,
  input wire logic bypass_i,
  output logic ser_o,
  output logic ser_vld_o
);

  // ********************************************************
  // Functions
  // ********************************************************
  // Sync normalisation of one 10-bit component word
  // An 8-bit source leaves the two low bits at zero, so without this its sync
  // codes would reach the line as 3fc instead of the full 10-bit 3ff
  function automatic logic [9:0] sync_map(input logic [9:0] w, input logic inhibit);
    logic [9:0] r;
    r = w;
    if (!inhibit) begin
      if (w[hdtx_pkg::SYNC_HI_MSB:hdtx_pkg::SYNC_HI_LSB] == hdtx_pkg::SYNC_HI_ZERO) begin
        r[hdtx_pkg::SYNC_LO_W-1:0] = hdtx_pkg::SYNC_LO_ZERO;
      end else if (w[hdtx_pkg::SYNC_HI_MSB:hdtx_pkg::SYNC_HI_LSB] == hdtx_pkg::SYNC_HI_ONE) begin
        r[hdtx_pkg::SYNC_LO_W-1:0] = hdtx_pkg::SYNC_LO_ONE;
      end
    end
    return r;
  endfunction

  // ********************************************************
  // Declarations
  // ********************************************************
  logic pclk_q;
  logic pclk_d;
  logic [hdtx_pkg::WORD_W-1:0] in_word_q;
  logic [hdtx_pkg::WORD_W-1:0] in_word_d;
  logic inh_q;
  logic inh_d;
  logic byp_in_q;
  logic byp_in_d;
  logic have_q;
  logic have_d;
  logic [hdtx_pkg::WORD_W-1:0] shift_q;
  logic [hdtx_pkg::WORD_W-1:0] shift_d;
  logic byp_q;
  logic byp_d;
  logic ld_vld_q;
  logic ld_vld_d;
  logic vld_q;
  logic vld_d;
  logic edge_det;
  logic [hdtx_pkg::HALF_W-1:0] map_c;
  logic [hdtx_pkg::HALF_W-1:0] map_y;

  // ********************************************************
  // Input capture
  // ********************************************************
  // Rising edge of the parallel clock, sampled on the bit clock
  // pclk_i is a plain synchronous input; it must be low through reset so the
  // first sample after release is not taken as a false edge
  assign edge_det = pclk_i & ~pclk_q;

  // Latch the full word and its controls once per parallel period
  always_comb begin
    pclk_d = pclk_i;
    in_word_d = in_word_q;
    inh_d = inh_q;
    byp_in_d = byp_in_q;
    have_d = have_q;
    if (edge_det) begin
      in_word_d = data_i;
      inh_d = sync_map_inhibit_i;
      byp_in_d = bypass_i;
      have_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pclk_q <= 1'b0;
      in_word_q <= hdtx_pkg::WORD_RST;
      inh_q <= 1'b0;
      byp_in_q <= 1'b0;
      have_q <= 1'b0;
    end else begin
      pclk_q <= pclk_d;
      in_word_q <= in_word_d;
      inh_q <= inh_d;
      byp_in_q <= byp_in_d;
      have_q <= have_d;
    end
  end

  // ********************************************************
  // Interleave and sync mapping
  // ********************************************************
  // Both halves normalised; 8-bit sources get full 10-bit sync codes
  assign map_c = sync_map(in_word_q[hdtx_pkg::CHROMA_MSB:hdtx_pkg::CHROMA_LSB], inh_q);
  assign map_y = sync_map(in_word_q[hdtx_pkg::LUMA_MSB:hdtx_pkg::LUMA_LSB], inh_q);

  // ********************************************************
  // Serialiser
  // ********************************************************
  // Load chroma in the low half so it leaves first, then luma; shift LSB first
  // One word of latency: the word captured at one parallel rise is loaded at
  // the next rise, while the following word is being captured.
  // A rise sooner than twenty bit clocks cuts the word short; a later one
  // shifts zeros, which the coder scrambles unless the word is bypassed.
  always_comb begin
    shift_d = {1'b0, shift_q[hdtx_pkg::WORD_W-1:1]};
    byp_d = byp_q;
    ld_vld_d = ld_vld_q;
    vld_d = ld_vld_q;
    if (edge_det) begin
      shift_d = {map_y, map_c};
      byp_d = byp_in_q;
      ld_vld_d = have_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      shift_q <= hdtx_pkg::WORD_RST;
      byp_q <= 1'b0;
      ld_vld_q <= 1'b0;
      vld_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      byp_q <= byp_d;
      ld_vld_q <= ld_vld_d;
      vld_q <= vld_d;
    end
  end

  // Scrambler and NRZI act on each serial bit; output registered inside
  hdtx_coder u_coder (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .bit_i(shift_q[0]),
    .bypass_i(byp_q),
    .bit_o(ser_o)
  );

  assign ser_vld_o = vld_q;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  // Capture and hold of the parallel word, then load, sync mapping, shift, bypass and valid
  a_word_capture: assert property (edge_det |=> in_word_q == $past(data_i))
    else $error("Input word not captured on parallel clock rise");
  a_word_hold: assert property (!edge_det |=> $stable(in_word_q))
    else $error("Input word changed between parallel edges");
  a_luma_load: assert property (edge_det |=> shift_q[19:10] == sync_map($past(in_word_q[19:10]), $past(inh_q)))
    else $error("Luma half loaded wrongly");
  a_chroma_first: assert property (edge_det |=> shift_q[9:0] == sync_map($past(in_word_q[9:0]), $past(inh_q)))
    else $error("Chroma half loaded wrongly");
  a_sync_zero: assert property ((!inh_q && in_word_q[9:2] == 8'h00) |-> map_c == 10'h000)
    else $error("Zero sync word not normalised");
  a_sync_one: assert property ((!inh_q && in_word_q[19:12] == 8'hff) |-> map_y == 10'h3ff)
    else $error("Ones sync word not normalised");
  a_map_inhibit: assert property (inh_q |-> {map_y, map_c} == in_word_q)
    else $error("Inhibited word was modified");
  a_lsb_first: assert property (!edge_det |=> shift_q[18:0] == $past(shift_q[19:1]))
    else $error("Serial shift not LSB first");
  a_bypass_raw: assert property (byp_q |=> ser_o == $past(shift_q[0]))
    else $error("Bypass bit altered");
  a_valid_pipe: assert property (edge_det && have_q |=> ##1 ser_vld_o)
    else $error("Valid not raised after word load");

  // Per-word controls travel with their word into the shifter
  a_inhibit_latch: assert property (edge_det |=> inh_q == $past(sync_map_inhibit_i))
    else $error("Inhibit not captured with the word");
  a_bypass_latch: assert property (edge_det |=> byp_in_q == $past(bypass_i))
    else $error("Bypass not captured with the word");
  a_bypass_load: assert property (edge_det |=> byp_q == $past(byp_in_q))
    else $error("Bypass not passed to the shifter");
  a_bypass_hold: assert property (!edge_det |=> $stable(byp_q))
    else $error("Bypass changed inside a word");

  // Sync mapping on the other code of each half, and pass-through of data codes
  a_luma_zero: assert property ((!inh_q && in_word_q[19:12] == 8'h00) |-> map_y == 10'h000)
    else $error("Zero sync luma word not normalised");
  a_chroma_one: assert property ((!inh_q && in_word_q[9:2] == 8'hff) |-> map_c == 10'h3ff)
    else $error("Ones sync chroma word not normalised");
  a_chroma_pass: assert property ((in_word_q[9:2] != 8'h00 && in_word_q[9:2] != 8'hff)
    |-> map_c == in_word_q[9:0])
    else $error("Chroma data word altered by sync mapping");
  a_luma_pass: assert property ((in_word_q[19:12] != 8'h00 && in_word_q[19:12] != 8'hff)
    |-> map_y == in_word_q[19:10])
    else $error("Luma data word altered by sync mapping");

  // Shifter fills with zeros; valid and the word flag hold until reset
  a_shift_fill: assert property (!edge_det |=> !shift_q[19])
    else $error("Shifter not zero filled");
  a_valid_hold: assert property (ser_vld_o |=> ser_vld_o)
    else $error("Valid dropped without reset");
  a_word_seen: assert property (have_q |=> have_q)
    else $error("Word flag dropped without reset");

  c_sync_word: cover property (edge_det && !sync_map_inhibit_i && data_i[9:2] == 8'h00);
  c_bypass_word: cover property (edge_det && bypass_i);
  c_valid_rise: cover property (!ser_vld_o ##1 ser_vld_o);
  c_sync_one: cover property (edge_det && !sync_map_inhibit_i && data_i[19:12] == 8'hff);
  c_inhibit_word: cover property (edge_det && sync_map_inhibit_i && data_i[9:2] == 8'h00);

endmodule

// ==== hdtx_src_model.sv ====
// Upstream parallel video source model: one word per parallel clock period
`timescale 1ns/1ps
module hdtx_src_model (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [19:0] word_i,
  input wire logic inhibit_i,
  input wire logic bypass_i,
  output logic take_o,
  output logic pclk_o,
  output logic [19:0] data_o,
  output logic sync_map_inhibit_o,
  output logic bypass_o
);
  // ********************************************************
  // Parallel clock phase and word launch
  // ********************************************************
  logic [4:0] cnt_q;

  // Twenty bit periods per word, parallel clock high for the first ten
  always_ff @(negedge core_clk_i) begin
    if (srst_i) begin
      cnt_q <= 5'h13;
    end else begin
      cnt_q <= (cnt_q == 5'h13) ? 5'h00 : cnt_q + 5'h01;
    end
  end

  assign take_o = (cnt_q == 5'h13);
  assign pclk_o = (cnt_q < 5'h0a);

  // New word launched with the parallel clock rise, held the whole period
  always_ff @(negedge core_clk_i) begin
    if (srst_i) begin
      data_o <= 20'h00000;
      sync_map_inhibit_o <= 1'b0;
      bypass_o <= 1'b0;
    end else if (take_o) begin
      data_o <= word_i;
      sync_map_inhibit_o <= inhibit_i;
      bypass_o <= bypass_i;
    end
  end
endmodule

// ==== tb.sv ====
// Self-checking bench for the HD serial transmit coding path
`timescale 1ns/1ps
module tb;
  logic core_clk_i = 1'b1;
  logic srst_i = 1'b1;
  logic [19:0] word_d = 20'h00000;
  logic inh_d = 1'b0;
  logic byp_d = 1'b0;
  logic take, pclk, sync_inh, bypass, ser_o, ser_vld_o;
  logic [19:0] data;
  logic [31:0] rnd = 32'h29c73954;
  logic [8:0] ref_lfsr = 9'h000;
  logic ref_nrzi = 1'b0;
  logic exp_q[$];
  int bad_count = 0;
  int checks = 0;
  int i;

  always #5 core_clk_i = ~core_clk_i;

  hdtx_src_model hdtx_src_model_i (.core_clk_i, .srst_i, .word_i(word_d), .inhibit_i(inh_d), .bypass_i(byp_d),
    .take_o(take), .pclk_o(pclk), .data_o(data), .sync_map_inhibit_o(sync_inh), .bypass_o(bypass));
  hdtx_serializer hdtx_serializer_i (.core_clk_i, .srst_i, .pclk_i(pclk), .data_i(data),
    .sync_map_inhibit_i(sync_inh), .bypass_i(bypass), .ser_o, .ser_vld_o);

  // ********************************************************
  // Reference model and drivers
  // ********************************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [9:0] map_half(input logic [9:0] h, input logic inh);
    if (!inh && h[9:2] == 8'h00) return 10'h000;
    if (!inh && h[9:2] == 8'hff) return 10'h3ff;
    return h;
  endfunction

  // Expected serial bits: chroma then luma, LSB first, scrambled and NRZI coded unless bypassed
  task automatic push_word(input logic [19:0] w, input logic inh, input logic byp);
    logic [19:0] m;
    logic s;
    m = {map_half(w[19:10], inh), map_half(w[9:0], inh)};
    for (int k = 0; k < 20; k++) begin
      if (byp) begin
        exp_q.push_back(m[k]);
      end else begin
        s = m[k] ^ ref_lfsr[3] ^ ref_lfsr[8];
        ref_lfsr = {ref_lfsr[7:0], s};
        ref_nrzi = s ^ ref_nrzi;
        exp_q.push_back(ref_nrzi);
      end
    end
  endtask

  // Hand a word to the source and note its bits once the source takes it
  task automatic send_word(input logic [19:0] w, input logic inh, input logic byp);
    word_d <= w;
    inh_d <= inh;
    byp_d <= byp;
    do @(negedge core_clk_i); while (take !== 1'b1);
    push_word(w, inh, byp);
  endtask

  task automatic do_reset();
    @(negedge core_clk_i);
    srst_i <= 1'b1;
    repeat (12) @(negedge core_clk_i);
    checks++;
    if (ser_vld_o !== 1'b0) begin
      bad_count++;
      $display("[ERR] %0t valid flag high in reset", $time);
    end
    exp_q.delete();
    ref_lfsr = 9'h000;
    ref_nrzi = 1'b0;
    srst_i <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Serial watcher, one bit per cycle against the oldest expectation
  always @(negedge core_clk_i) begin
    if (!srst_i && ser_vld_o === 1'b1 && exp_q.size() > 0) begin
      checks++;
      if (ser_o !== exp_q.pop_front()) begin
        bad_count++;
        $display("[ERR] %0t serial bit mismatch", $time);
      end
    end
  end

  // ********************************************************
  // Tests
  // ********************************************************
  initial begin
    do_reset();
    for (i = 0; i < 30; i++) begin
      rnd = lfsr_next(rnd);
      send_word(rnd[19:0], rnd[20], 1'b0);
    end
    $display("test random_coded done");
    for (i = 0; i < 16; i++) begin
      send_word({10'h3fb + 10'(i % 5), 10'h000 + 10'(i % 5)}, i[3], 1'b0);
    end
    $display("test sync_codes done");
    for (i = 0; i < 20; i++) begin
      rnd = lfsr_next(rnd);
      send_word(rnd[19:0], 1'b0, rnd[25]);
    end
    for (i = 0; i < 6; i++) begin
      send_word(i[1] ? 20'hfffff : 20'h00000, 1'b1, 1'b0);
    end
    $display("test bypass_runs done");
    do_reset();
    for (i = 0; i < 6; i++) begin
      rnd = lfsr_next(rnd);
      send_word(rnd[19:0], 1'b0, 1'b0);
    end
    repeat (50) @(negedge core_clk_i);
    if (checks < 1000) begin
      bad_count++;
      $display("[ERR] %0t too few serial bits seen", $time);
    end
    $display("test mid_reset done");
    print_verdict();
  end

  // Watchdog well beyond the expected run of about 1600 cycles
  initial begin
    #100000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
